// [inc/qrp_params.svh]
// Purpose: constants for the readout pipeline
// Assumes: 12-bit byte address, 32-bit words
// Notes:   coefficients are signed q2.14, weights q1.15
`ifndef QRP_PARAMS_SVH
`define QRP_PARAMS_SVH
`define QRP_A_CTRL       12'h000
`define QRP_A_LEN        12'h004
`define QRP_A_DLY        12'h008
`define QRP_A_ERR        12'h00c
`define QRP_A_IST        12'h010
`define QRP_A_IMSK       12'h014
`define QRP_A_STATE      12'h018
`define QRP_A_WADR       12'h01c
`define QRP_A_DSK        12'h020
`define QRP_A_WDAT       12'h03c
`define QRP_A_ROT        12'h040
`define QRP_A_THR        12'h080
`define QRP_A_CORR       12'h0c0
`define QRP_A_RES        12'h100
`define QRP_A_XT         12'h200
`define QRP_COEF_ONE     16'h4000
`define QRP_COEF_FRAC    14
`define QRP_W_FRAC       15
`define QRP_STD_MAX_LEN  4096
`define QRP_SPEC_MAX_LEN 24'hffffff
`define QRP_TSEL_SEQ     3'h4
`define QRP_IRQ_DONE     0
`define QRP_IRQ_HOLD     1
`endif

// [inc/qrp_pkg.sv]
// Purpose: types for the readout pipeline
// Assumes: nothing
// Notes:   one-hot sequencer states
package qrp_pkg;
    typedef enum logic [5:0] {
        QRP_IDLE  = 6'h01,
        QRP_DELAY = 6'h02,
        QRP_INTEG = 6'h04,
        QRP_ROT   = 6'h08,
        QRP_XT    = 6'h10,
        QRP_OUT   = 6'h20
    } qrp_state_t;
endpackage

// [sim/qrp_readout_tb.sv]
// Purpose: self-checking bench for the readout pipeline
// Assumes: WDEPTH cut to 16, all channels get weights, only ch0 crosstalk
// Notes:   crosstalk rows 1..9 stay zero, so their states are known
`timescale 1ns/1ps
`include "qrp_params.svh"
module qrp_readout_tb;
    logic        clk_i, nrst_i, wr_i, rd_i, rd_q;
    logic        seq_trig_i, result_valid_o, osc_sync_o, irq_o;
    logic [15:0] adc_a_i, adc_b_i, osc_cos_i, osc_sin_i;
    logic [3:0]  ext_trig_i;
    logic [11:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [9:0]  qubit_state_o;
    int          n_errors, checks_done, cyc;
    logic [31:0] rq[$];
    logic [9:0]  sq[$];
    int          cq[$];
    longint      a, b, e;

    qrp_readout #(.WDEPTH(16)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .adc_a_i(adc_a_i),
        .adc_b_i(adc_b_i), .ext_trig_i(ext_trig_i), .seq_trig_i(seq_trig_i),
        .osc_cos_i(osc_cos_i), .osc_sin_i(osc_sin_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .qubit_state_o(qubit_state_o),
        .result_valid_o(result_valid_o), .osc_sync_o(osc_sync_o), .irq_o(irq_o));
    qrp_src_model u_src (.clk_i(clk_i), .adc_a_o(adc_a_i), .adc_b_o(adc_b_i),
        .ext_trig_o(ext_trig_i), .seq_trig_o(seq_trig_i), .osc_cos_o(osc_cos_i),
        .osc_sin_o(osc_sin_i));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= ad;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
        rq.push_back(exp);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // bounded wait until the monitor has taken every result note
    task automatic wait_res;
        for (int i = 0; i < 200 && cq.size() != 0; i++)
            @(posedge clk_i);
        if (cq.size() != 0)
        begin
            n_errors++;
            conclude();
        end
    endtask
    // weights 0.5, crosstalk 1.0: truncation exact for positive samples
    function automatic longint calc(longint d, longint l, longint x);
        return (((l * d * 16384) >>> 15) * x) >>> 14;
    endfunction
    task automatic run(input logic [2:0] src);
        logic [15:0] x;
        logic [9:0]  st;
        x = src[0] ? 16'h2000 : 16'h4000;
        a = $urandom_range(2000, 1);
        b = $urandom_range(2000, 1);
        u_src.set_pair(a[15:0], b[15:0]);
        if (src == 3'h2)
        begin
            wr(`QRP_A_DSK, 32'h0);
            wr(`QRP_A_DSK + 12'h4, 32'h4000);
        end
        e = calc(src >= 3'h2 ? b : a, 4, x);
        st = {7'h0, 1'b1, 1'b0, src[0]};
        wr(`QRP_A_CTRL, {25'h0, src, 4'h0});
        wr(`QRP_A_DLY, {29'h0, src});
        wr(`QRP_A_ROT, {16'h0, x});
        wr(`QRP_A_THR, e[31:0] - {31'h0, src[0]});
        @(posedge clk_i);
        sq.push_back(st);
        cq.push_back(src == 3'h4 ? cyc + 9 + 4 : 0);
        u_src.fire(src);
        if (src == 3'h4)
        begin
            repeat (2) @(posedge clk_i);
            u_src.fire(src);
        end
        wait_res();
        rd(`QRP_A_RES, e[31:0]);
        rd(`QRP_A_STATE, {22'h0, st});
    endtask

    // ****************************************
    // result and read-data monitor
    // ****************************************
    always @(posedge clk_i)
    begin
        cyc  <= cyc + 1;
        rd_q <= rd_i;
        if (rd_q)
            check(rdata_o, rq.pop_front());
        if (result_valid_o === 1'b1)
        begin
            check({22'h0, qubit_state_o}, {22'h0, sq.pop_front()});
            if (cq[0] != 0)
                check(32'(cyc), 32'(cq[0]));
            void'(cq.pop_front());
        end
    end

    initial
    begin
        {nrst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        void'($urandom(32'hb8a6edf7));
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(`QRP_A_DSK, 32'h4000);
        rd(`QRP_A_DSK + 12'h4, 32'h0);
        rd(`QRP_A_DSK + 12'h8, 32'h0);
        rd(`QRP_A_DSK + 12'hc, 32'h4000);
        rd(12'h3fc, 32'h0);
        // weights for every channel: unwritten words would turn the crosstalk sum unknown
        for (int c = 0; c < 10; c++)
        begin
            wr(`QRP_A_WADR, {12'h0, 4'(c), 16'h0});
            repeat (4) wr(`QRP_A_WDAT, 32'h40004000);
        end
        wr(`QRP_A_LEN, 32'h4);
        wr(`QRP_A_XT, 32'h4000);
        wr(`QRP_A_THR + 12'h8, 32'hffffffff);
        for (int s = 0; s < 5; s++)
            run(s[2:0]);
        // oscillator reference, window past weight depth
        wr(`QRP_A_CTRL, 32'h41);
        wr(`QRP_A_LEN, 32'd20);
        wr(`QRP_A_CORR, 32'h100);
        e = calc(b, 20, 16'h4000);
        wr(`QRP_A_THR, e[31:0] - 32'h1);
        @(posedge clk_i);
        sq.push_back(10'h005);
        cq.push_back(cyc + 9 + 20);
        u_src.fire(3'h4);
        #1;
        check({31'h0, osc_sync_o}, 32'h1);
        wait_res();
        e = (e * e) >>> 14;
        rd(`QRP_A_RES, e[31:0]);
        rd(`QRP_A_ERR, 32'h1);
        rd(`QRP_A_IST, 32'h3);
        #1;
        check({31'h0, irq_o}, 32'h0);
        wr(`QRP_A_IMSK, 32'h2);
        #1;
        check({31'h0, irq_o}, 32'h1);
        wr(`QRP_A_IST, 32'h2);
        #1;
        check({31'h0, irq_o}, 32'h0);
        rd(`QRP_A_IST, 32'h1);
        wr(`QRP_A_ERR, 32'h0);
        rd(`QRP_A_ERR, 32'h0);
        repeat (4) @(posedge clk_i);
        conclude();
    end
endmodule

// [sim/qrp_src_model.sv]
// Purpose: sample pair and trigger source facing the readout pipeline
// Assumes: samples change only when the bench asks
// Notes:   ext triggers held 4 cycles so the 2-flop sync sees them
`timescale 1ns/1ps
module qrp_src_model (
    input  wire logic   clk_i,
    output logic [15:0] adc_a_o,
    output logic [15:0] adc_b_o,
    output logic [3:0]  ext_trig_o,
    output logic        seq_trig_o,
    output logic [15:0] osc_cos_o,
    output logic [15:0] osc_sin_o
);
    logic [2:0] hold_cnt;
    // equal 0.5 references: result does not hinge on cos/sin pairing
    assign osc_cos_o = 16'h4000;
    assign osc_sin_o = 16'h4000;
    initial
    begin
        adc_a_o    = 16'h0000;
        adc_b_o    = 16'h0000;
        ext_trig_o = 4'h0;
        seq_trig_o = 1'b0;
        hold_cnt   = 3'h0;
    end
    task automatic set_pair(input logic [15:0] av, input logic [15:0] bv);
        adc_a_o <= av;
        adc_b_o <= bv;
    endtask
    // called at a rising edge; source 4 is the sequencer pulse
    task automatic fire(input logic [2:0] src);
        if (src == 3'h4)
            seq_trig_o <= 1'b1;
        else
            ext_trig_o[src[1:0]] <= 1'b1;
    endtask
    always @(posedge clk_i)
    begin
        if (seq_trig_o)
            seq_trig_o <= 1'b0;
        if (|ext_trig_o)
            hold_cnt <= hold_cnt + 3'h1;
        if (hold_cnt == 3'h3)
        begin
            ext_trig_o <= 4'h0;
            hold_cnt   <= 3'h0;
        end
    end
endmodule

// [verilog/qrp_readout.sv]
// Purpose: deskew, weighted integration, rotation, crosstalk, correlation, threshold
// Assumes: one sample pair per clk_i, samples and ext triggers asynchronous pins
// Notes:   products are truncated, not saturated
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "qrp_params.svh"
module qrp_readout #(
    parameter int          N_CH     = 10,
    parameter int          WDEPTH   = `QRP_STD_MAX_LEN,
    parameter logic [23:0] SPEC_MAX = `QRP_SPEC_MAX_LEN
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] adc_a_i,
    input  wire logic [15:0] adc_b_i,
    input  wire logic [3:0]  ext_trig_i,
    input  wire logic        seq_trig_i,
    input  wire logic [15:0] osc_cos_i,
    input  wire logic [15:0] osc_sin_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output logic [N_CH-1:0]  qubit_state_o,
    output logic             result_valid_o,
    output logic             osc_sync_o,
    output logic             irq_o
);
    // ****************************************
    // parameter check
    // ****************************************
    if (N_CH < 1 || N_CH > 16 || WDEPTH < 1 || WDEPTH > `QRP_STD_MAX_LEN)
    begin : g_bad_param
        $error("qrp_readout: N_CH must be 1..16 and WDEPTH 1..4096");
    end

    typedef struct packed {
        qrp_pkg::qrp_state_t         fsm;
        logic                        mode;
        logic [2:0]                  tsel;
        logic [23:0]                 len;
        logic [23:0]                 dly;
        logic [23:0]                 cnt;
        logic [31:0]                 err;
        logic [1:0]                  ist;
        logic [1:0]                  imsk;
        logic [3:0]                  wch;
        logic [11:0]                 widx;
        logic [3:0][15:0]            dsk;
        logic [N_CH-1:0][31:0]       rot;
        logic [N_CH-1:0][31:0]       thr;
        logic [N_CH-1:0][31:0]       res;
        logic [N_CH-1:0][31:0]       ri;
        logic [N_CH-1:0][31:0]       xi;
        logic [N_CH-1:0]             cen;
        logic [N_CH-1:0]             qst;
        logic [N_CH-1:0][3:0]        csrc;
        logic [N_CH*N_CH-1:0][15:0]  xt;
        logic [1:0][15:0]            sa;
        logic [1:0][15:0]            sb;
        logic [15:0]                 da;
        logic [15:0]                 db;
        logic [3:0]                  t1;
        logic [3:0]                  t2;
        logic [3:0]                  t3;
        logic [N_CH-1:0][47:0]       ai;
        logic [N_CH-1:0][47:0]       aq;
        logic [31:0]                 rdata;
        logic                        done;
    } qrp_st_t;

    qrp_st_t            st_reg;
    qrp_st_t            st_next;
    logic [31:0]        wmem [N_CH*WDEPTH];
    logic               trig;
    logic [3:0]         edge_det;
    logic [23:0]        lmax;
    logic [23:0]        elen;
    logic signed [32:0] pa;
    logic signed [32:0] pb;
    logic signed [63:0] m0;
    logic signed [63:0] m1;
    logic [31:0]        wword;
    logic [15:0]        wi;
    logic [15:0]        wq;

    function automatic logic [11:0] adr(input logic [11:0] base, input int i);
        return 12'(base + 4 * i);
    endfunction

    // ****************************************
    // trigger selection
    // ****************************************
    assign edge_det = st_reg.t2 & ~st_reg.t3;
    assign trig = (st_reg.tsel == `QRP_TSEL_SEQ) ? seq_trig_i :
                  (st_reg.tsel[2] ? 1'b0 : edge_det[st_reg.tsel[1:0]]);
    assign lmax = st_reg.mode ? SPEC_MAX : 24'(WDEPTH);
    assign elen = (st_reg.len == 24'h0) ? 24'h1 : ((st_reg.len > lmax) ? lmax : st_reg.len);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_next = st_reg;
        m0 = 64'sh0;
        m1 = 64'sh0;
        wword = 32'h0;
        wi = 16'h0;
        wq = 16'h0;
        st_next.done = 1'b0;
        st_next.rdata = 32'h0;
        // first stage feeds only the second
        st_next.sa = {st_reg.sa[0], adc_a_i};
        st_next.sb = {st_reg.sb[0], adc_b_i};
        st_next.t1 = ext_trig_i;
        st_next.t2 = st_reg.t1;
        st_next.t3 = st_reg.t2;
        pa = $signed(st_reg.dsk[0]) * $signed(st_reg.sa[1]) + $signed(st_reg.dsk[1]) * $signed(st_reg.sb[1]);
        pb = $signed(st_reg.dsk[2]) * $signed(st_reg.sa[1]) + $signed(st_reg.dsk[3]) * $signed(st_reg.sb[1]);
        st_next.da = 16'(pa >>> `QRP_COEF_FRAC);
        st_next.db = 16'(pb >>> `QRP_COEF_FRAC);
        case (st_reg.fsm)
            qrp_pkg::QRP_IDLE:
            begin
                if (trig)
                begin
                    st_next.fsm = (st_reg.dly == 24'h0) ? qrp_pkg::QRP_INTEG : qrp_pkg::QRP_DELAY;
                    st_next.cnt = 24'h0;
                    st_next.ai = '0;
                    st_next.aq = '0;
                end
            end
            qrp_pkg::QRP_DELAY:
            begin
                st_next.cnt = st_reg.cnt + 24'h1;
                if (st_reg.cnt == st_reg.dly - 24'h1)
                begin
                    st_next.fsm = qrp_pkg::QRP_INTEG;
                    st_next.cnt = 24'h0;
                end
            end
            qrp_pkg::QRP_INTEG:
            begin
                for (int q = 0; q < N_CH; q++)
                begin
                    wword = st_reg.mode ? 32'h0 : wmem[q * WDEPTH + int'(st_reg.cnt[11:0])];
                    wi = st_reg.mode ? osc_cos_i : wword[15:0];
                    wq = st_reg.mode ? osc_sin_i : wword[31:16];
                    st_next.ai[q] = 48'($signed(st_reg.ai[q]) + $signed(st_reg.da) * $signed(wi));
                    st_next.aq[q] = 48'($signed(st_reg.aq[q]) + $signed(st_reg.db) * $signed(wq));
                end
                st_next.cnt = st_reg.cnt + 24'h1;
                if (st_reg.cnt == elen - 24'h1)
                begin
                    st_next.fsm = qrp_pkg::QRP_ROT;
                end
            end
            qrp_pkg::QRP_ROT:
            begin
                // complex rotation, only in-phase goes on
                for (int q = 0; q < N_CH; q++)
                begin
                    m0 = $signed(st_reg.ai[q][46:15]) * $signed(st_reg.rot[q][15:0]);
                    m1 = $signed(st_reg.aq[q][46:15]) * $signed(st_reg.rot[q][31:16]);
                    st_next.ri[q] = 32'((m0 - m1) >>> `QRP_COEF_FRAC);
                end
                st_next.fsm = qrp_pkg::QRP_XT;
            end
            qrp_pkg::QRP_XT:
            begin
                // crosstalk matrix, wide but one cycle at this rate
                for (int r = 0; r < N_CH; r++)
                begin
                    m0 = 64'sh0;
                    for (int c = 0; c < N_CH; c++)
                    begin
                        m0 = m0 + $signed(st_reg.xt[r * N_CH + c]) * $signed(st_reg.ri[c]);
                    end
                    st_next.xi[r] = 32'(m0 >>> `QRP_COEF_FRAC);
                end
                st_next.fsm = qrp_pkg::QRP_OUT;
            end
            qrp_pkg::QRP_OUT:
            begin
                for (int q = 0; q < N_CH; q++)
                begin
                    st_next.qst[q] = $signed(st_reg.xi[q]) > $signed(st_reg.thr[q]);
                    m1 = (int'(st_reg.csrc[q]) < N_CH) ? 64'($signed(st_reg.xi[st_reg.csrc[q]])) : 64'sh0;
                    m0 = $signed(st_reg.xi[q]) * m1;
                    st_next.res[q] = st_reg.cen[q] ? 32'(m0 >>> `QRP_COEF_FRAC) : st_reg.xi[q];
                end
                st_next.done = 1'b1;
                st_next.fsm = qrp_pkg::QRP_IDLE;
            end
            default:
            begin
                st_next.fsm = qrp_pkg::QRP_IDLE;
            end
        endcase

        // ****************************************
        // register port
        // ****************************************
        if (wr_i)
        begin
            case (addr_i)
                `QRP_A_CTRL:
                begin
                    st_next.mode = wdata_i[0];
                    st_next.tsel = wdata_i[6:4];
                end
                `QRP_A_LEN:  st_next.len = wdata_i[23:0];
                `QRP_A_DLY:  st_next.dly = wdata_i[23:0];
                `QRP_A_ERR:  st_next.err = 32'h0;
                `QRP_A_IST:  st_next.ist = st_reg.ist & ~wdata_i[1:0];
                `QRP_A_IMSK: st_next.imsk = wdata_i[1:0];
                `QRP_A_WADR:
                begin
                    st_next.wch = wdata_i[19:16];
                    st_next.widx = wdata_i[11:0];
                end
                `QRP_A_WDAT: st_next.widx = st_reg.widx + 12'h1;
                default:
                begin
                end
            endcase
            for (int i = 0; i < 4; i++)
            begin
                if (addr_i == adr(`QRP_A_DSK, i))
                begin
                    st_next.dsk[i] = wdata_i[15:0];
                end
            end
            for (int q = 0; q < N_CH; q++)
            begin
                if (addr_i == adr(`QRP_A_ROT, q))
                begin
                    st_next.rot[q] = wdata_i;
                end
                if (addr_i == adr(`QRP_A_THR, q))
                begin
                    st_next.thr[q] = wdata_i;
                end
                if (addr_i == adr(`QRP_A_CORR, q))
                begin
                    st_next.cen[q] = wdata_i[8];
                    st_next.csrc[q] = wdata_i[3:0];
                end
            end
            for (int i = 0; i < N_CH * N_CH; i++)
            begin
                if (addr_i == adr(`QRP_A_XT, i))
                begin
                    st_next.xt[i] = wdata_i[15:0];
                end
            end
        end
        if (rd_i)
        begin
            case (addr_i)
                `QRP_A_CTRL:  st_next.rdata = {25'h0, st_reg.tsel, 3'h0, st_reg.mode};
                `QRP_A_LEN:   st_next.rdata = {8'h0, st_reg.len};
                `QRP_A_DLY:   st_next.rdata = {8'h0, st_reg.dly};
                `QRP_A_ERR:   st_next.rdata = st_reg.err;
                `QRP_A_IST:   st_next.rdata = {30'h0, st_reg.ist};
                `QRP_A_IMSK:  st_next.rdata = {30'h0, st_reg.imsk};
                `QRP_A_STATE: st_next.rdata = 32'(st_reg.qst);
                `QRP_A_WADR:  st_next.rdata = {12'h0, st_reg.wch, 4'h0, st_reg.widx};
                default:      st_next.rdata = 32'h0;
            endcase
            for (int i = 0; i < 4; i++)
            begin
                if (addr_i == adr(`QRP_A_DSK, i))
                begin
                    st_next.rdata = 32'($signed(st_reg.dsk[i]));
                end
            end
            for (int q = 0; q < N_CH; q++)
            begin
                if (addr_i == adr(`QRP_A_ROT, q))
                begin
                    st_next.rdata = st_reg.rot[q];
                end
                if (addr_i == adr(`QRP_A_THR, q))
                begin
                    st_next.rdata = st_reg.thr[q];
                end
                if (addr_i == adr(`QRP_A_CORR, q))
                begin
                    st_next.rdata = {23'h0, st_reg.cen[q], 4'h0, st_reg.csrc[q]};
                end
                if (addr_i == adr(`QRP_A_RES, q))
                begin
                    st_next.rdata = st_reg.res[q];
                end
            end
        end

        // ****************************************
        // events: set wins over clear
        // ****************************************
        // hold-off violation count
        if (trig && st_reg.fsm != qrp_pkg::QRP_IDLE)
        begin
            st_next.err = st_next.err + 32'h1;
            st_next.ist[`QRP_IRQ_HOLD] = 1'b1;
        end
        if (st_next.done)
        begin
            st_next.ist[`QRP_IRQ_DONE] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_reg <= '0;
            st_reg.fsm <= qrp_pkg::QRP_IDLE;
            st_reg.dsk <= {`QRP_COEF_ONE, 16'h0, 16'h0, `QRP_COEF_ONE};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // weights kept out of reset, too large to clear
    always_ff @(posedge clk_i)
    begin
        if (wr_i && addr_i == `QRP_A_WDAT && int'(st_reg.wch) < N_CH && int'(st_reg.widx) < WDEPTH)
        begin
            wmem[int'(st_reg.wch) * WDEPTH + int'(st_reg.widx)] <= wdata_i;
        end
    end

    assign rdata_o        = st_reg.rdata;
    assign qubit_state_o  = st_reg.qst;
    assign result_valid_o = st_reg.done;
    assign osc_sync_o     = trig && st_reg.mode && st_reg.fsm == qrp_pkg::QRP_IDLE;
    assign irq_o          = |(st_reg.ist & st_reg.imsk);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_dsk_reset_ident: assert property ($rose(nrst_i)
        |-> st_reg.dsk[0] == `QRP_COEF_ONE && st_reg.dsk[1] == 16'h0)
        else $error("deskew not identity after reset");
    chk_dsk_pass_thru: assert property (st_reg.dsk == {`QRP_COEF_ONE, 16'h0, 16'h0, `QRP_COEF_ONE}
        |=> st_reg.da == $past(st_reg.sa[1]))
        else $error("identity deskew altered sample");
    chk_trig_no_delay: assert property (st_reg.fsm == qrp_pkg::QRP_IDLE && trig && st_reg.dly == 24'h0
        |=> st_reg.fsm == qrp_pkg::QRP_INTEG)
        else $error("integration did not start");
    chk_delay_two: assert property (st_reg.fsm == qrp_pkg::QRP_IDLE && trig && st_reg.dly == 24'h2
        |=> st_reg.fsm == qrp_pkg::QRP_DELAY [*2] ##1 st_reg.fsm == qrp_pkg::QRP_INTEG)
        else $error("delay length wrong");
    chk_std_len_max: assert property (st_reg.fsm == qrp_pkg::QRP_INTEG && !st_reg.mode
        |-> int'(st_reg.cnt) < WDEPTH)
        else $error("standard integration too long");
    chk_holdoff_count: assert property (trig && st_reg.fsm != qrp_pkg::QRP_IDLE
        |=> st_reg.err == $past(st_reg.err) + 32'h1 || $past(wr_i && addr_i == `QRP_A_ERR))
        else $error("hold-off not counted");
    chk_stage_order: assert property (st_reg.fsm == qrp_pkg::QRP_ROT |=> st_reg.fsm == qrp_pkg::QRP_XT
        ##1 st_reg.fsm == qrp_pkg::QRP_OUT ##1 st_reg.done && st_reg.ist[`QRP_IRQ_DONE])
        else $error("stage order broken");
    chk_thr_bit: assert property (st_reg.done
        |-> st_reg.qst[0] == ($signed($past(st_reg.xi[0])) > $signed($past(st_reg.thr[0]))))
        else $error("state bit wrong");
    chk_seq_source: assert property (st_reg.tsel == `QRP_TSEL_SEQ && seq_trig_i
        && st_reg.fsm == qrp_pkg::QRP_IDLE |=> st_reg.fsm != qrp_pkg::QRP_IDLE)
        else $error("sequencer trigger not routed");
    chk_state_read: assert property (rd_i && addr_i == `QRP_A_STATE
        |=> rdata_o[N_CH-1:0] == $past(st_reg.qst))
        else $error("state readback wrong");

    cov_delay_run: cover property (st_reg.fsm == qrp_pkg::QRP_DELAY ##1 st_reg.fsm == qrp_pkg::QRP_INTEG);
    cov_holdoff: cover property (trig && st_reg.fsm == qrp_pkg::QRP_INTEG);
    cov_spec_done: cover property (st_reg.mode && st_reg.done);
endmodule
